// [src/power_save_mode_controller.sv]
// power-save mode controller: sleep, idle and doze sequencing
// assumes core, interrupt controller and watchdog sit on I_CLK_SYS
//
// The AHB-Lite slave port and the address map were left to the implementer.
`include "pwr_save_defines.svh"

// Overview of operation
// - low power entered only by power-save instruction; operand picks sleep or idle
// - sleep halts execution, stops system clock and on-chip oscillator
// - sleep freezes every io direction and level
// - fail-safe clock monitor off during sleep
// - rc oscillator runs in sleep if watchdog or timers select it
// - enabled watchdog cleared on sleep and idle entry
// - sleep disables system-clocked peripherals; change notify, external clocks run
// - wake on enabled interrupt, any reset, or watchdog time-out
// - after sleep restart on same clock source as at entry
// - idle stops cpu, keeps system clock, peripherals run
// - rc oscillator runs in idle if watchdog or clock monitor on
// - idle wake reapplies cpu clock at once
// - interrupt during entry deferred until entry done, then wakes
// - wakeup pin low in sleep wakes device and sets flag bit 0
// - module enable bit 15 and sink enable bit 8 discharge pin
// - stop-in-idle bit 13 halts wakeup module in idle
// - unimplemented wakeup control bits read zero; implemented reset zero
// - doze slows only cpu clock, synchronised with peripherals
// - doze active while doze enable bit 11 set
// - ratio bits 14:12 give 1:1 to 1:128, default 1:1
// - return-on-interrupt bit 15 makes interrupt restore full speed
module power_save_mode_controller
   import pwr_save_pkg::*;
(
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_ARST_N,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HSEL,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        i_psv_exec,
   input  wire logic        i_psv_operand,
   input  wire logic        i_irq_pending,
   input  wire logic        i_wdt_timeout,
   input  wire logic        i_wdt_enable,
   input  wire logic        i_fail_safe_clock_monitor_enable,
   input  wire logic        i_low_power_rc_oscillator_selected,
   input  wire logic        i_wakeup_pin_low,
   input  wire logic        i_osc_onchip,
   output logic             O_CPU_RUN,
   output logic             O_CPU_CLK_EN,
   output logic             O_SYS_CLK_EN,
   output logic             O_OSC_EN,
   output logic             O_IO_FREEZE,
   output logic             O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE,
   output logic             O_LOW_POWER_RC_OSCILLATOR_EN,
   output logic             O_WDT_CLEAR,
   output logic             O_PERIPH_SYSCLK_EN,
   output logic             O_WAKEUP_SINK_EN,
   output logic             O_IN_SLEEP,
   output logic             O_IN_IDLE
);
   import pwr_save_pkg::*;

   //************************************************************
   // bus address phase capture
   //************************************************************
   logic       wr_pend_r, wr_pend_nxt;
   logic       rd_pend_r, rd_pend_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic       take;

   assign take = HSEL && HREADY && HTRANS[1];

   always_comb begin
      wr_pend_nxt = take && HWRITE;
      rd_pend_nxt = take && !HWRITE;
      addr_nxt    = take ? HADDR[7:0] : addr_r;
   end

   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= 8'h00;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         rd_pend_r <= rd_pend_nxt;
         addr_r    <= addr_nxt;
      end
   end

   //************************************************************
   // mode sequencer
   //************************************************************
   pmode_e state_r, state_nxt;
   logic   sleep_r, sleep_nxt;
   logic   osc_src_r, osc_src_nxt;
   logic   wdt_clr_nxt;
   logic   deferred_r, deferred_nxt;
   logic   wake_cause;
   logic   wpc_en_r, wpc_sidl_r, wpc_sink_r;
   logic   wpc_en_nxt, wpc_sidl_nxt, wpc_sink_nxt;
   logic   flag_r, flag_nxt;
   logic   wakeup_active;
   logic   wakeup_hit;

   assign wakeup_active = wpc_en_r && wpc_sink_r
                          && !(state_r == ST_LOW && !sleep_r
                               && wpc_sidl_r);
   assign wakeup_hit = wakeup_active && i_wakeup_pin_low
                       && state_r == ST_LOW && sleep_r;
   assign wake_cause = i_irq_pending || i_wdt_timeout
                       || deferred_r || wakeup_hit;

   always_comb begin
      state_nxt    = state_r;
      sleep_nxt    = sleep_r;
      osc_src_nxt  = osc_src_r;
      wdt_clr_nxt  = 1'b0;
      deferred_nxt = deferred_r;
      unique case (state_r)
         ST_RUN: begin
            if (i_psv_exec) begin
               state_nxt   = ST_ENTER;
               sleep_nxt   = (i_psv_operand == `PSV_OP_SLEEP);
               osc_src_nxt = i_osc_onchip;
               wdt_clr_nxt = i_wdt_enable;
            end
         end
         ST_ENTER: begin
            deferred_nxt = i_irq_pending;
            state_nxt    = ST_LOW;
         end
         ST_LOW: begin
            if (wake_cause) begin
               state_nxt    = ST_WAKE;
               deferred_nxt = 1'b0;
            end
         end
         ST_WAKE: begin
            state_nxt = ST_RUN;
            sleep_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state_r     <= ST_RUN;
         sleep_r     <= 1'b0;
         osc_src_r   <= 1'b0;
         deferred_r  <= 1'b0;
         O_WDT_CLEAR <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         sleep_r     <= sleep_nxt;
         osc_src_r   <= osc_src_nxt;
         deferred_r  <= deferred_nxt;
         O_WDT_CLEAR <= wdt_clr_nxt;
      end
   end

   //************************************************************
   // registers
   //************************************************************
   logic        roi_r, roi_nxt;
   doze_ratio_t ratio_r, ratio_nxt;
   logic        doze_enable_r, doze_enable_nxt;
   logic [15:0] wd;
   logic [15:0] wpc_rd, cdr_rd;
   logic [31:0] rdata_nxt;

   assign wd = HWDATA[15:0];
   assign wpc_rd = {wpc_en_r, 1'b0, wpc_sidl_r, 4'h0, wpc_sink_r,
                    8'h00};
   assign cdr_rd = {roi_r, ratio_r, doze_enable_r, 11'h000};

   always_comb begin
      wpc_en_nxt   = wpc_en_r;
      wpc_sidl_nxt = wpc_sidl_r;
      wpc_sink_nxt = wpc_sink_r;
      roi_nxt      = roi_r;
      ratio_nxt    = ratio_r;
      doze_enable_nxt    = doze_enable_r;
      flag_nxt     = flag_r;
      if (wr_pend_r) begin
         unique case (addr_r)
            `OFS_WAKEUP_PIN_CONTROL: begin
               wpc_en_nxt   = wd[`WPC_MODULE_ENABLE];
               wpc_sidl_nxt = wd[`WPC_STOP_IN_IDLE];
               wpc_sink_nxt = wd[`WPC_SINK_ENABLE];
            end
            `OFS_CLOCK_DIVIDER_REG: begin
               roi_nxt   = wd[`CDR_RETURN_ON_INT];
               ratio_nxt = wd[`CDR_RATIO_HI:`CDR_RATIO_LO];
               doze_enable_nxt = wd[`CDR_DOZE_ENABLE];
            end
            `OFS_INTERRUPT_FLAG_REG_5: begin
               flag_nxt = wd[`INTERRUPT_FLAG_REG_5_WAKEUP_FLAG];
            end
            default: begin
            end
         endcase
      end
      if (doze_enable_r && roi_r && i_irq_pending) begin
         doze_enable_nxt = 1'b0;
      end
      if (wakeup_hit) begin
         flag_nxt = 1'b1;
      end
      rdata_nxt = 32'h0000_0000;
      if (take && !HWRITE) begin
         unique case (HADDR[7:0])
            `OFS_WAKEUP_PIN_CONTROL:   rdata_nxt = {16'h0000, wpc_rd};
            `OFS_CLOCK_DIVIDER_REG:    rdata_nxt = {16'h0000, cdr_rd};
            `OFS_POWER_STATUS:
               rdata_nxt = {29'h0, deferred_r, state_r};
            `OFS_INTERRUPT_FLAG_REG_5: rdata_nxt = {31'h0, flag_r};
            default:                   rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wpc_en_r   <= 1'b0;
         wpc_sidl_r <= 1'b0;
         wpc_sink_r <= 1'b0;
         roi_r      <= 1'b0;
         ratio_r    <= 3'h0;
         doze_enable_r    <= 1'b0;
         flag_r     <= 1'b0;
         HRDATA     <= 32'h0000_0000;
      end else begin
         wpc_en_r   <= wpc_en_nxt;
         wpc_sidl_r <= wpc_sidl_nxt;
         wpc_sink_r <= wpc_sink_nxt;
         roi_r      <= roi_nxt;
         ratio_r    <= ratio_nxt;
         doze_enable_r    <= doze_enable_nxt;
         flag_r     <= flag_nxt;
         HRDATA     <= rdata_nxt;
      end
   end

   //************************************************************
   // doze cpu clock enable
   //************************************************************
   logic cpu_tick;

   doze_divider u_doze (
      .i_clk      (I_CLK_SYS),
      .i_arst_n   (I_ARST_N),
      .i_active   (doze_enable_r),
      .i_ratio    (ratio_r),
      .o_cpu_tick (cpu_tick)
   );

   //************************************************************
   // output flops
   //************************************************************
   logic low_nxt, slp_nxt, idl_nxt;

   always_comb begin
      low_nxt = (state_nxt == ST_LOW);
      slp_nxt = low_nxt && sleep_nxt;
      idl_nxt = low_nxt && !sleep_nxt;
   end

   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         HREADYOUT          <= 1'b1;
         HRESP              <= 1'b0;
         O_CPU_RUN          <= 1'b1;
         O_CPU_CLK_EN       <= 1'b1;
         O_SYS_CLK_EN       <= 1'b1;
         O_OSC_EN           <= 1'b1;
         O_IO_FREEZE        <= 1'b0;
         O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE      <= 1'b0;
         O_LOW_POWER_RC_OSCILLATOR_EN          <= 1'b0;
         O_PERIPH_SYSCLK_EN <= 1'b1;
         O_WAKEUP_SINK_EN   <= 1'b0;
         O_IN_SLEEP         <= 1'b0;
         O_IN_IDLE          <= 1'b0;
      end else begin
         HREADYOUT          <= 1'b1;
         HRESP              <= 1'b0;
         O_CPU_RUN          <= !(state_nxt == ST_ENTER) && !low_nxt;
         O_CPU_CLK_EN       <= !low_nxt && cpu_tick;
         O_SYS_CLK_EN       <= !slp_nxt;
         O_OSC_EN           <= !(slp_nxt && osc_src_nxt);
         O_IO_FREEZE        <= slp_nxt;
         O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE      <= i_fail_safe_clock_monitor_enable && !slp_nxt;
         O_LOW_POWER_RC_OSCILLATOR_EN          <= slp_nxt ? i_low_power_rc_oscillator_selected
                               : (i_wdt_enable || i_fail_safe_clock_monitor_enable);
         O_PERIPH_SYSCLK_EN <= !slp_nxt;
         O_WAKEUP_SINK_EN   <= wakeup_active;
         O_IN_SLEEP         <= slp_nxt;
         O_IN_IDLE          <= idl_nxt;
      end
   end
endmodule : power_save_mode_controller

// [shared/pwr_save_defines.svh]
// register offsets, field positions and reset values of the power-save block
// assumes inclusion by bare name from the design files
`ifndef PWR_SAVE_DEFINES_SVH
`define PWR_SAVE_DEFINES_SVH
`define OFS_WAKEUP_PIN_CONTROL  8'h00
`define OFS_CLOCK_DIVIDER_REG   8'h04
`define OFS_POWER_CTRL          8'h08
`define OFS_POWER_STATUS        8'h0C
`define OFS_INTERRUPT_FLAG_REG_5 8'h10
`define WPC_MODULE_ENABLE       15
`define WPC_STOP_IN_IDLE        13
`define WPC_SINK_ENABLE         8
`define WPC_IMPL_MASK           16'hA100
`define CDR_RETURN_ON_INT       15
`define CDR_RATIO_HI            14
`define CDR_RATIO_LO            12
`define CDR_DOZE_ENABLE         11
`define CDR_IMPL_MASK           16'hF800
`define CDR_RESET               16'h0000
`define WPC_RESET               16'h0000
`define INTERRUPT_FLAG_REG_5_WAKEUP_FLAG        0
`define PSV_OP_SLEEP            1'b0
`define PSV_OP_IDLE             1'b1
`endif

// [shared/pwr_save_pkg.sv]
// types shared by the power-save controller files
// assumes nothing of its surroundings
package pwr_save_pkg;
   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_ENTER = 2'b01,
      ST_LOW   = 2'b11,
      ST_WAKE  = 2'b10
   } pmode_e;
   typedef logic [2:0] doze_ratio_t;
endpackage : pwr_save_pkg

// [src/doze_divider.sv]
// cpu clock enable divider for doze mode
// assumes system clock is the peripheral clock
module doze_divider
   import pwr_save_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   input  wire logic              i_active,
   input  wire pwr_save_pkg::doze_ratio_t i_ratio,
   output logic                   o_cpu_tick
);
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic       tick_nxt;
   logic [6:0] limit;

   always_comb begin
      limit    = 7'((8'h01 << i_ratio) - 8'h01);
      tick_nxt = 1'b0;
      cnt_nxt  = cnt_r;
      if (!i_active || cnt_r >= limit) begin
         cnt_nxt  = 7'h00;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt  = 7'(cnt_r + 7'h01);
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r      <= 7'h00;
         o_cpu_tick <= 1'b1;
      end else begin
         cnt_r      <= cnt_nxt;
         o_cpu_tick <= tick_nxt;
      end
   end
endmodule : doze_divider

// [verification/power_save_props.sv]
// checker of the power-save controller port relations
// assumes binding to the controller, one system clock domain
module power_save_props (
   input wire logic I_CLK_SYS,
   input wire logic I_ARST_N,
   input wire logic i_psv_exec,
   input wire logic i_psv_operand,
   input wire logic i_irq_pending,
   input wire logic i_wdt_timeout,
   input wire logic i_wdt_enable,
   input wire logic i_fail_safe_clock_monitor_enable,
   input wire logic i_low_power_rc_oscillator_selected,
   input wire logic i_osc_onchip,
   input wire logic O_CPU_RUN,
   input wire logic O_SYS_CLK_EN,
   input wire logic O_OSC_EN,
   input wire logic O_IO_FREEZE,
   input wire logic O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE,
   input wire logic O_LOW_POWER_RC_OSCILLATOR_EN,
   input wire logic O_WDT_CLEAR,
   input wire logic O_PERIPH_SYSCLK_EN,
   input wire logic O_IN_SLEEP,
   input wire logic O_IN_IDLE
);
   //****************************
   // properties
   //****************************
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_ARST_N);
   sequence s_exec;
      O_CPU_RUN && !O_IN_SLEEP && !O_IN_IDLE && i_psv_exec;
   endsequence
   sequence s_cause;
      (O_IN_SLEEP || O_IN_IDLE) && (i_irq_pending || i_wdt_timeout);
   endsequence
   sequence s_asleep;
      O_IN_SLEEP && !O_SYS_CLK_EN && O_IO_FREEZE && !O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE
         && !O_PERIPH_SYSCLK_EN;
   endsequence
   chk_run_stop: assert property (s_exec |=> !O_CPU_RUN)
      else $error("core ran on after power-save");
   chk_wdt_clear: assert property (s_exec ##0 i_wdt_enable |=> O_WDT_CLEAR)
      else $error("watchdog not cleared on entry");
   chk_sleep_entry: assert property (s_exec ##0 !i_psv_operand |-> ##2 s_asleep)
      else $error("sleep entry outputs wrong");
   chk_idle_entry: assert property (s_exec ##0 i_psv_operand |-> ##2
      (O_IN_IDLE && O_SYS_CLK_EN && O_PERIPH_SYSCLK_EN && !O_CPU_RUN))
      else $error("idle entry outputs wrong");
   chk_wake_time: assert property (s_cause |-> ##[1:3] O_CPU_RUN)
      else $error("no wake after cause");
   chk_defer_irq: assert property (s_exec ##1 i_irq_pending |-> ##[2:5] O_CPU_RUN)
      else $error("coincident interrupt lost");
   chk_low_power_rc_oscillator_sleep: assert property (O_IN_SLEEP && $past(O_IN_SLEEP)
      && $stable(i_low_power_rc_oscillator_selected) && i_low_power_rc_oscillator_selected |-> O_LOW_POWER_RC_OSCILLATOR_EN)
      else $error("rc oscillator stopped in sleep");
   chk_low_power_rc_oscillator_idle: assert property (O_IN_IDLE && $past(O_IN_IDLE) &&
      $stable(i_wdt_enable) && $stable(i_fail_safe_clock_monitor_enable)
      && (i_wdt_enable || i_fail_safe_clock_monitor_enable) |-> O_LOW_POWER_RC_OSCILLATOR_EN)
      else $error("rc oscillator stopped in idle");
   chk_osc_source: assert property (O_IN_SLEEP && $stable(i_osc_onchip)
      |-> O_OSC_EN == !i_osc_onchip)
      else $error("oscillator state wrong in sleep");
endmodule : power_save_props

bind power_save_mode_controller power_save_props chk (.*);

// [verification/core_model.sv]
// core and interrupt controller model issuing power-save requests
// assumes the bench calls its tasks between clock edges
module core_model (
   input  wire logic i_clk,
   input  wire logic i_cpu_run,
   output logic      o_psv_exec,
   output logic      o_psv_operand,
   output logic      o_irq_pending
);
   timeunit 1ns;
   timeprecision 1ps;
   logic irq_req = 1'h0;
   initial begin
      o_psv_exec = 1'h0;
      o_psv_operand = 1'h0;
      o_irq_pending = 1'h0;
   end
   // pending holds until the core runs again outside the instruction
   always @(posedge i_clk) begin
      o_irq_pending <= irq_req | (o_irq_pending & ~(i_cpu_run & ~o_psv_exec));
   end
   task automatic exec(input logic op, input logic with_irq);
      @(posedge i_clk);
      o_psv_exec <= 1'h1;
      o_psv_operand <= op;
      irq_req <= with_irq;
      @(posedge i_clk);
      o_psv_exec <= 1'h0;
      o_psv_operand <= ~op;
      irq_req <= 1'h0;
   endtask : exec
   task automatic raise_irq();
      irq_req <= 1'h1;
      @(posedge i_clk);
      irq_req <= 1'h0;
   endtask : raise_irq
endmodule : core_model

// [verification/power_save_mode_controller_bench.sv]
// bench of the power-save controller: bus, sleep, idle, wake-up, doze
// assumes core_model as partner and power_save_props bound to the dut
`include "pwr_save_defines.svh"
module power_save_mode_controller_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import pwr_save_pkg::*;
   logic clk = 1'h0, arst_n = 1'h0, hwrite = 1'h0, hsel = 1'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, cnt;
   logic [1:0] htrans = 2'h0;
   logic wdt_to = 1'h0, wdt_en = 1'h0, fail_safe_clock_monitor_en = 1'h0, low_power_rc_oscillator_sel = 1'h0;
   logic pin_low = 1'h0, osc_oc = 1'h0, rd_dp = 1'h0, pw_dp = 1'h0;
   logic psv, op, irq, hready, hresp, run, cclk, sys, osc, frz, fail_safe_clock_monitor;
   logic low_power_rc_oscillator, wclr, per, sink, slp, idl;
   logic [63:0] note;
   logic [15:0] v;
   logic [2:0] r;
   logic [63:0] q[$];
   int seed = 73879, failures = 0, n_compared = 0, cycles = 0, i;
   wire [9:0] stat = {run, sys, osc, frz, fail_safe_clock_monitor, low_power_rc_oscillator, per, sink, slp, idl};
   power_save_mode_controller dut (.I_CLK_SYS(clk), .I_ARST_N(arst_n),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
      .HWDATA(hwdata), .HSEL(hsel), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .i_psv_exec(psv),
      .i_psv_operand(op), .i_irq_pending(irq), .i_wdt_timeout(wdt_to),
      .i_wdt_enable(wdt_en), .i_fail_safe_clock_monitor_enable(fail_safe_clock_monitor_en),
      .i_low_power_rc_oscillator_selected(low_power_rc_oscillator_sel), .i_wakeup_pin_low(pin_low),
      .i_osc_onchip(osc_oc), .O_CPU_RUN(run), .O_CPU_CLK_EN(cclk),
      .O_SYS_CLK_EN(sys), .O_OSC_EN(osc), .O_IO_FREEZE(frz),
      .O_FAIL_SAFE_CLOCK_MONITOR_ACTIVE(fail_safe_clock_monitor), .O_LOW_POWER_RC_OSCILLATOR_EN(low_power_rc_oscillator), .O_WDT_CLEAR(wclr),
      .O_PERIPH_SYSCLK_EN(per), .O_WAKEUP_SINK_EN(sink),
      .O_IN_SLEEP(slp), .O_IN_IDLE(idl));
   core_model core (.i_clk(clk), .i_cpu_run(run), .o_psv_exec(psv),
      .o_psv_operand(op), .o_irq_pending(irq));
   //****************************
   // checking
   //****************************
   always #5 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         final_report();
      end
      if (rd_dp || pw_dp) begin
         note = q.pop_front();
         check((rd_dp ? hrdata : {22'h0, stat}) & note[63:32], note[31:0]);
         check({31'h0, hresp}, 32'h0);
      end
   end
   //****************************
   // drivers
   //****************************
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [15:0] d, input logic [15:0] e);
      @(posedge clk);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsel <= 1'h1;
      do @(posedge clk); while (hready !== 1'h1);
      htrans <= 2'h0;
      hwdata <= {16'($random(seed)), d};
      if (!w) q.push_back({32'hFFFFFFFF, 16'h0, e});
      rd_dp <= !w;
      do @(posedge clk); while (hready !== 1'h1);
      rd_dp <= 1'h0;
   endtask : bus
   task automatic expect_out(input logic [9:0] m, input logic [9:0] e);
      q.push_back({22'h0, m, 22'h0, e});
      pw_dp <= 1'h1;
      @(posedge clk);
      pw_dp <= 1'h0;
   endtask : expect_out
   task automatic wake_wdt();
      wdt_to <= 1'h1;
      @(posedge clk);
      wdt_to <= 1'h0;
      for (int k = 0; k < 40 && run !== 1'h1; k++) @(posedge clk);
      expect_out(10'h3CB, 10'h388);
   endtask : wake_wdt
   task automatic count_ticks(input logic [31:0] exp);
      cnt = 32'h0;
      repeat (4) @(posedge clk);
      repeat (128) begin
         @(negedge clk);
         cnt += cclk;
      end
      check(cnt, exp);
   endtask : count_ticks
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'h1;
      bus(0, `OFS_CLOCK_DIVIDER_REG, 16'h0, 16'h0000);
      bus(1, `OFS_POWER_CTRL, 16'hFFFF, 16'h0);
      bus(0, `OFS_POWER_CTRL, 16'h0, 16'h0000);
      bus(0, `OFS_WAKEUP_PIN_CONTROL, 16'h0, 16'h0000);
      for (i = 0; i < 3; i++) begin
         v = (i == 0) ? 16'h0100 : (i == 1) ? 16'h8000 : 16'hFFFF;
         bus(1, `OFS_WAKEUP_PIN_CONTROL, v, 16'h0);
         bus(0, `OFS_WAKEUP_PIN_CONTROL, 16'h0, v & 16'hA100);
         expect_out(10'h004, (i == 2) ? 10'h004 : 10'h000);
      end
      wdt_en <= 1'h0;
      fail_safe_clock_monitor_en <= 1'h1;
      low_power_rc_oscillator_sel <= 1'h1;
      for (i = 0; i < 2; i++) begin
         v = (i == 0) ? 16'hFFFF : 16'h8100;
         bus(1, `OFS_WAKEUP_PIN_CONTROL, v, 16'h0);
         core.exec(1'h1, 1'h0);
         repeat (2) @(posedge clk);
         expect_out(10'h35F, v[13] ? 10'h119 : 10'h11D);
         wake_wdt();
      end
      wdt_en <= 1'h1;
      core.exec(1'h0, 1'h0);
      repeat (2) @(posedge clk);
      expect_out(10'h006, 10'h006);
      pin_low <= 1'h1;
      for (int k = 0; k < 40 && run !== 1'h1; k++) @(posedge clk);
      pin_low <= 1'h0;
      bus(0, `OFS_INTERRUPT_FLAG_REG_5, 16'h0, 16'h0001);
      bus(1, `OFS_INTERRUPT_FLAG_REG_5, 16'h0, 16'h0);
      bus(0, `OFS_INTERRUPT_FLAG_REG_5, 16'h0, 16'h0000);
      bus(1, `OFS_WAKEUP_PIN_CONTROL, 16'h0, 16'h0);
      for (i = 0; i < 2; i++) begin
         osc_oc <= !i[0];
         core.exec(1'h0, 1'h0);
         repeat (2) @(posedge clk);
         expect_out(10'h3FF, i[0] ? 10'h0D2 : 10'h052);
         if (i == 0) begin
            core.raise_irq();
            for (int k = 0; k < 40 && run !== 1'h1; k++) @(posedge clk);
            expect_out(10'h3CB, 10'h388);
         end else
            wake_wdt();
      end
      core.exec(1'h1, 1'h1);
      @(posedge clk);
      expect_out(10'h201, 10'h001);
      for (int k = 0; k < 40 && run !== 1'h1; k++) @(posedge clk);
      expect_out(10'h3CB, 10'h388);
      core.exec(1'h0, 1'h0);
      repeat (3) @(posedge clk);
      arst_n <= 1'h0;
      repeat (2) @(posedge clk);
      arst_n <= 1'h1;
      expect_out(10'h3CB, 10'h388);
      for (i = 0; i < 8; i++) begin
         bus(1, `OFS_CLOCK_DIVIDER_REG, 16'h0800 | (16'(i) << 12), 16'h0);
         count_ticks(32'h80 >> i);
      end
      r = 3'($random(seed));
      bus(1, `OFS_CLOCK_DIVIDER_REG, 16'h8800 | (16'(r) << 12), 16'h0);
      core.raise_irq();
      repeat (3) @(posedge clk);
      bus(0, `OFS_CLOCK_DIVIDER_REG, 16'h0, 16'h8000 | (16'(r) << 12));
      bus(1, `OFS_CLOCK_DIVIDER_REG, 16'h0800 | (16'(r) << 12), 16'h0);
      core.raise_irq();
      repeat (3) @(posedge clk);
      bus(0, `OFS_CLOCK_DIVIDER_REG, 16'h0, 16'h0800 | (16'(r) << 12));
      bus(1, `OFS_CLOCK_DIVIDER_REG, 16'h0, 16'h0);
      count_ticks(32'h80);
      final_report();
   end
endmodule : power_save_mode_controller_bench
